// >>> verilog/acs_pkg.sv
// constants, types and helpers for the conversion sequence configuration
// How it works
// - bits 7:6 pick the sequence reference: bandgap, single pin, supply, pin pair.
// - bits 5:4 hold the sequence decimation choice, reset 01, used for all channels.
// - decimation codes 0..3 give rates 64,128,256,512 and 7,9,10,12 result bits.
// - bits 3:0 name the last channel of the sequence, zero after reset.
// - codes 0000..0111 convert single inputs from input 0 up to the named input.
// - codes 1000..1011 convert differential pairs from pair 0-1 up to the named pair.
// - codes 1100..1111 do one conversion of ground, reference, temperature or supply/3.
// - reading the end channel shows the latest conversion or the written value, whichever came last.
// - after a sequence below 1100 the read gives written plus one, else unchanged.
// - a finished extra conversion loads its own channel code into the field.
// - each conversion lasts rate plus 16 converter periods; converter clock is clock/6.
package acs_pkg;

	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_START = 8'hB4;
	localparam logic [7:0] IDX_SEQ = 8'hB5;
	localparam logic [7:0] IDX_EXTRA = 8'hB6;
	localparam int unsigned ADDR_W = 12;
	localparam logic [ADDR_W-1:0] ADDR_START = {2'h0, IDX_START, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_SEQ = {2'h0, IDX_SEQ, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_EXTRA = {2'h0, IDX_EXTRA, 2'h0};

	// field positions
	localparam int unsigned REF_LO = 6;
	localparam int unsigned DIV_LO = 4;
	localparam int unsigned CH_LO = 0;
	localparam int unsigned START_BIT = 6;
	localparam int unsigned DONE_BIT = 7;

	// reset values
	localparam logic [1:0] SEQ_REF_RST = 2'h0;
	localparam logic [1:0] SEQ_DIV_RST = 2'h1;
	localparam logic [3:0] SEQ_CH_RST = 4'h0;
	localparam logic [1:0] EXT_REF_RST = 2'h0;
	localparam logic [1:0] EXT_DIV_RST = 2'h0;
	localparam logic [3:0] EXT_CH_RST = 4'h0;

	// channel codes
	localparam logic [3:0] CH_FIRST_SINGLE = 4'h0;
	localparam logic [3:0] CH_LAST_SINGLE = 4'h7;
	localparam logic [3:0] CH_FIRST_DIFF = 4'h8;
	localparam logic [3:0] CH_FIRST_INTERNAL = 4'hC;
	localparam logic [3:0] CH_STEP = 4'h1;

	// reference codes
	localparam logic [1:0] REF_BANDGAP = 2'h0;
	localparam logic [1:0] REF_EXT_PIN = 2'h1;
	localparam logic [1:0] REF_SUPPLY = 2'h2;
	localparam logic [1:0] REF_EXT_PAIR = 2'h3;

	// timing
	localparam int unsigned CONV_CLK_DIV = 6;
	localparam int unsigned PERIOD_W = 10;
	localparam logic [PERIOD_W-1:0] SETTLE_PERIODS = 10'h010;
	localparam logic [PERIOD_W-1:0] RATE_64 = 10'h040;
	localparam logic [PERIOD_W-1:0] RATE_128 = 10'h080;
	localparam logic [PERIOD_W-1:0] RATE_256 = 10'h100;
	localparam logic [PERIOD_W-1:0] RATE_512 = 10'h200;
	localparam logic [3:0] RES_64 = 4'h7;
	localparam logic [3:0] RES_128 = 4'h9;
	localparam logic [3:0] RES_256 = 4'hA;
	localparam logic [3:0] RES_512 = 4'hC;

	// bus answers
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_ARM,
		ST_RUN
	} acs_state_e;

	typedef enum logic [1:0] {
		SEL_NONE,
		SEL_START,
		SEL_SEQ,
		SEL_EXTRA
	} acs_sel_e;

	// settings presented to the analog side
	typedef struct packed {
		logic busy;
		logic [3:0] channel;
		logic [1:0] refsel;
		logic [1:0] decim;
		logic [3:0] res_bits;
	} acs_conv_s;

	// decimation code to rate in converter periods
	function automatic logic [PERIOD_W-1:0] rate_of(input logic [1:0] div);
		case (div)
			2'h0: rate_of = RATE_64;
			2'h1: rate_of = RATE_128;
			2'h2: rate_of = RATE_256;
			default: rate_of = RATE_512;
		endcase
	endfunction

	// decimation code to result width
	function automatic logic [3:0] res_of(input logic [1:0] div);
		case (div)
			2'h0: res_of = RES_64;
			2'h1: res_of = RES_128;
			2'h2: res_of = RES_256;
			default: res_of = RES_512;
		endcase
	endfunction

	// byte address to register
	function automatic acs_sel_e addr_sel(input logic [ADDR_W-1:0] a);
		case (a)
			ADDR_START: addr_sel = SEL_START;
			ADDR_SEQ: addr_sel = SEL_SEQ;
			ADDR_EXTRA: addr_sel = SEL_EXTRA;
			default: addr_sel = SEL_NONE;
		endcase
	endfunction

endpackage

// >>> verilog/acs_conv_timer.sv
// conversion timer counting converter clock periods
`timescale 1ns/1ps
module acs_conv_timer
	import acs_pkg::*;
#(
	parameter int unsigned DIV = CONV_CLK_DIV
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// control
	input wire logic start,
	input wire logic [PERIOD_W-1:0] periods,
	// result
	output logic done
);

	localparam logic [2:0] PRE_LAST = 3'(DIV - 1);
	localparam logic [PERIOD_W-1:0] ONE = 10'h001;

	typedef struct packed {
		logic active;
		logic [2:0] pre;
		logic [PERIOD_W-1:0] cnt;
		logic [PERIOD_W-1:0] last;
		logic done;
	} acs_tmr_s;

	acs_tmr_s s_q;
	acs_tmr_s s_d;

	always_comb begin
		s_d = s_q;
		s_d.done = 1'b0;
		if (start) begin
			s_d.active = 1'b1;
			s_d.pre = 3'h0;
			s_d.cnt = '0;
			s_d.last = periods - ONE;
		end else if (s_q.active) begin
			// one converter period is DIV system clocks
			if (s_q.pre == PRE_LAST) begin
				s_d.pre = 3'h0;
				if (s_q.cnt == s_q.last) begin
					s_d.active = 1'b0;
					s_d.done = 1'b1;
				end else begin
					s_d.cnt = s_q.cnt + ONE;
				end
			end else begin
				s_d.pre = s_q.pre + 3'h1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign done = s_q.done;

endmodule

// >>> verilog/acs_seq_ctrl.sv
// conversion sequence configuration and sequencer with register slave
//
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/1ps
module acs_seq_ctrl
	import acs_pkg::*;
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// write address channel
	input wire logic awvalid,
	output logic awready,
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic [2:0] awprot,
	// write data channel
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	// write response channel
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	// read address channel
	input wire logic arvalid,
	output logic arready,
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic [2:0] arprot,
	// read data channel
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	// analog side
	output acs_conv_s conv,
	output logic sample_ready,
	output logic extra_done
);

	typedef struct packed {
		acs_state_e state;
		// bus
		logic aw_got;
		logic w_got;
		logic [ADDR_W-1:0] waddr;
		logic [7:0] wbyte;
		logic wlane;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [7:0] rbyte;
		logic [1:0] rresp;
		// software settings
		logic [1:0] sequence_reference_select;
		logic [1:0] sequence_decimation_select;
		logic [3:0] sch_set;
		logic [3:0] sch_show;
		logic [1:0] ext_ref;
		logic [1:0] ext_div;
		logic [3:0] ext_ch;
		logic ext_pend;
		logic seq_pend;
		logic seq_done;
		// captured for the running conversion
		logic [1:0] run_ref;
		logic [1:0] run_div;
		logic [3:0] run_end;
		logic [3:0] cur_ch;
		logic run_extra;
		// outputs
		acs_conv_s conv;
		logic timer_start;
		logic sample_pulse;
		logic extra_pulse;
	} acs_ctl_s;

	acs_ctl_s s_q;
	acs_ctl_s s_d;
	logic timer_done;
	logic seq_busy;
	logic start_req;
	logic [PERIOD_W-1:0] conv_periods;

	// channel codes at or above the first internal source
	function automatic logic is_internal(input logic [3:0] ch);
		is_internal = (ch >= CH_FIRST_INTERNAL);
	endfunction

	// rate plus settle time in converter periods
	assign conv_periods = rate_of(s_q.run_div) + SETTLE_PERIODS;

	acs_conv_timer #(
		.DIV(CONV_CLK_DIV)
	) u_timer (
		.aclk(aclk),
		.aresetn(aresetn),
		.start(s_q.timer_start),
		.periods(conv_periods),
		.done(timer_done)
	);

	assign seq_busy = s_q.seq_pend ||
		((s_q.state != ST_IDLE) && !s_q.run_extra);

	always_comb begin
		s_d = s_q;
		start_req = 1'b0;
		s_d.timer_start = 1'b0;
		s_d.sample_pulse = 1'b0;
		s_d.extra_pulse = 1'b0;

		// read channel
		if (s_q.rvalid && rready) begin
			s_d.rvalid = 1'b0;
		end
		if (arvalid && s_q.arready) begin
			s_d.rvalid = 1'b1;
			s_d.rresp = RESP_OKAY;
			case (addr_sel(araddr))
				SEL_START: begin
					s_d.rbyte = 8'h00;
					s_d.rbyte[DONE_BIT] = s_q.seq_done;
					s_d.rbyte[START_BIT] = seq_busy;
					s_d.seq_done = 1'b0;
				end
				SEL_SEQ: begin
					// latest conversion shown
					s_d.rbyte = {s_q.sequence_reference_select, s_q.sequence_decimation_select, s_q.sch_show};
				end
				SEL_EXTRA: begin
					s_d.rbyte = {s_q.ext_ref, s_q.ext_div, s_q.ext_ch};
				end
				default: begin
					s_d.rbyte = 8'h00;
					s_d.rresp = RESP_SLVERR;
				end
			endcase
		end

		// sequencer
		case (s_q.state)
			ST_IDLE: begin
				if (s_q.seq_pend) begin
					s_d.seq_pend = 1'b0;
					s_d.run_extra = 1'b0;
					// capture settings at start
					s_d.run_ref = s_q.sequence_reference_select;
					s_d.run_div = s_q.sequence_decimation_select;
					s_d.run_end = s_q.sch_set;
					if (s_q.sch_set <= CH_LAST_SINGLE) begin
						// singles from input 0
						s_d.cur_ch = CH_FIRST_SINGLE;
					end else if (!is_internal(s_q.sch_set)) begin
						// pairs from pair 0-1
						s_d.cur_ch = CH_FIRST_DIFF;
					end else begin
						// one internal source only
						s_d.cur_ch = s_q.sch_set;
					end
					s_d.state = ST_ARM;
				end else if (s_q.ext_pend) begin
					s_d.ext_pend = 1'b0;
					s_d.run_extra = 1'b1;
					s_d.run_ref = s_q.ext_ref;
					s_d.run_div = s_q.ext_div;
					s_d.run_end = s_q.ext_ch;
					s_d.cur_ch = s_q.ext_ch;
					s_d.state = ST_ARM;
				end
			end
			ST_ARM: begin
				// reference and rate drive every channel
				s_d.conv.busy = 1'b1;
				s_d.conv.channel = s_q.cur_ch;
				s_d.conv.refsel = s_q.run_ref;
				s_d.conv.decim = s_q.run_div;
				s_d.conv.res_bits = res_of(s_q.run_div);
				s_d.timer_start = 1'b1;
				s_d.state = ST_RUN;
			end
			ST_RUN: begin
				if (timer_done) begin
					if (s_q.run_extra) begin
						// extra result names its own channel
						s_d.sch_show = s_q.run_end;
						s_d.ext_ch = EXT_CH_RST;
						s_d.extra_pulse = 1'b1;
						s_d.conv.busy = 1'b0;
						s_d.state = ST_IDLE;
					end else begin
						s_d.sample_pulse = 1'b1;
						if (s_q.cur_ch == s_q.run_end) begin
							s_d.seq_done = 1'b1;
							s_d.conv.busy = 1'b0;
							s_d.state = ST_IDLE;
							// readback one past the end, or the end itself for an internal source
							if (!is_internal(s_q.run_end)) begin
								s_d.sch_show = s_q.run_end + CH_STEP;
							end else begin
								s_d.sch_show = s_q.run_end;
							end
						end else begin
							// ascending order
							s_d.cur_ch = s_q.cur_ch + CH_STEP;
							s_d.state = ST_ARM;
						end
					end
				end
			end
			default: begin
				s_d.state = ST_IDLE;
			end
		endcase

		// write channels
		if (s_q.bvalid && bready) begin
			s_d.bvalid = 1'b0;
		end
		if (awvalid && s_q.awready) begin
			s_d.aw_got = 1'b1;
			s_d.waddr = awaddr;
		end
		if (wvalid && s_q.wready) begin
			s_d.w_got = 1'b1;
			s_d.wbyte = wdata[7:0];
			s_d.wlane = wstrb[0];
		end
		if (s_q.aw_got && s_q.w_got) begin
			s_d.aw_got = 1'b0;
			s_d.w_got = 1'b0;
			s_d.bvalid = 1'b1;
			s_d.bresp = RESP_OKAY;
			case (addr_sel(s_q.waddr))
				SEL_START: begin
					if (s_q.wlane && s_q.wbyte[START_BIT] && !seq_busy) begin
						start_req = 1'b1;
					end
				end
				SEL_SEQ: begin
					if (s_q.wlane) begin
						s_d.sequence_reference_select = s_q.wbyte[REF_LO +: 2];
						s_d.sequence_decimation_select = s_q.wbyte[DIV_LO +: 2];
						s_d.sch_set = s_q.wbyte[CH_LO +: 4];
						s_d.sch_show = s_q.wbyte[CH_LO +: 4];
					end
				end
				SEL_EXTRA: begin
					if (s_q.wlane) begin
						s_d.ext_ref = s_q.wbyte[REF_LO +: 2];
						s_d.ext_div = s_q.wbyte[DIV_LO +: 2];
						s_d.ext_ch = s_q.wbyte[CH_LO +: 4];
						s_d.ext_pend = 1'b1;
					end
				end
				default: begin
					s_d.bresp = RESP_SLVERR;
				end
			endcase
		end
		if (start_req) begin
			s_d.seq_pend = 1'b1;
		end

		// readies follow the next state
		s_d.awready = !s_d.aw_got && !s_d.bvalid;
		s_d.wready = !s_d.w_got && !s_d.bvalid;
		s_d.arready = !s_d.rvalid;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_q <= '0;
			s_q.state <= ST_IDLE;
			s_q.sequence_reference_select <= SEQ_REF_RST;
			s_q.sequence_decimation_select <= SEQ_DIV_RST;
			s_q.sch_set <= SEQ_CH_RST;
			s_q.sch_show <= SEQ_CH_RST;
			s_q.ext_ref <= EXT_REF_RST;
			s_q.ext_div <= EXT_DIV_RST;
			s_q.ext_ch <= EXT_CH_RST;
			s_q.conv.res_bits <= RES_64;
		end else begin
			s_q <= s_d;
		end
	end

	// outputs
	assign awready = s_q.awready;
	assign wready = s_q.wready;
	assign bvalid = s_q.bvalid;
	assign bresp = s_q.bresp;
	assign arready = s_q.arready;
	assign rvalid = s_q.rvalid;
	assign rdata = {24'h000000, s_q.rbyte};
	assign rresp = s_q.rresp;
	assign conv = s_q.conv;
	assign sample_ready = s_q.sample_pulse;
	assign extra_done = s_q.extra_pulse;

endmodule

// >>> sim/acs_seq_ctrl_checker.sv
// assertions on the sequence controller ports
`timescale 1ns/1ps
module acs_seq_ctrl_checker
	import acs_pkg::*;
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// bus
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic bvalid,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic rvalid,
	input wire logic [31:0] rdata,
	// analog side
	input wire acs_conv_s conv,
	input wire logic sample_ready,
	input wire logic extra_done
);
	logic [2:0] gap_q;
	logic [2:0] gap_d;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// cycles since the last completion
	always_comb begin
		gap_d = (gap_q == 3'h7) ? gap_q : gap_q + 3'h1;
		if (!conv.busy || sample_ready || extra_done) begin
			gap_d = 3'h0;
		end
	end
	always_ff @(posedge aclk) begin
		gap_q <= aresetn ? gap_d : 3'h0;
	end
	a_res_map: assert property (
		conv.busy |-> conv.res_bits == (conv.decim == 2'h0 ? 4'h7 :
		conv.decim == 2'h1 ? 4'h9 : conv.decim == 2'h2 ? 4'hA : 4'hC))
		else $error("result width wrong");
	a_conv_time: assert property (
		$rose(conv.busy) && conv.decim == 2'h0 |->
		##[476:486] (sample_ready || extra_done))
		else $error("conversion time wrong");
	a_no_early: assert property (
		$rose(conv.busy) |=> !(sample_ready || extra_done) [*8])
		else $error("conversion ended early");
	a_settings_hold: assert property (
		gap_q >= 3'h4 && !sample_ready && !extra_done |=>
		sample_ready || extra_done || ($stable(conv.channel) &&
		$stable(conv.refsel) && $stable(conv.decim)))
		else $error("settings moved mid conversion");
	a_busy_pulse: assert property (
		sample_ready |-> $past(conv.busy))
		else $error("sample pulse while idle");
	a_pulse_one: assert property (sample_ready |=> !sample_ready)
		else $error("sample pulse too long");
	a_write_resp: assert property (
		awvalid && awready && wvalid && wready |-> ##2 bvalid)
		else $error("write answer late");
	a_read_lat: assert property (arvalid && arready |=> rvalid)
		else $error("read answer late");
	a_rdata_high: assert property (rvalid |-> rdata[31:8] == 24'h0)
		else $error("read data upper bits set");
endmodule

bind acs_seq_ctrl acs_seq_ctrl_checker acs_seq_ctrl_checker_i (.aclk,
	.aresetn, .awvalid, .awready, .wvalid, .wready, .bvalid, .arvalid,
	.arready, .rvalid, .rdata, .conv, .sample_ready, .extra_done);

// >>> sim/acs_analog_model.sv
// far-side model recording the settings of each finished conversion
`timescale 1ns/1ps
module acs_analog_model
	import acs_pkg::*;
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// converter settings and completions
	input wire acs_conv_s conv,
	input wire logic sample_ready,
	input wire logic extra_done
);
	acs_conv_s held;
	acs_conv_s seen[$];
	always @(posedge aclk) begin
		if (aresetn && (sample_ready || extra_done)) begin
			seen.push_back(held);
		end
		if (conv.busy) begin
			held = conv;
		end
	end
endmodule

// >>> sim/test_acs_seq_ctrl.sv
// self-checking bench for the sequence controller
`timescale 1ns/1ps
module test_acs_seq_ctrl;
	import acs_pkg::*;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid, sample_ready, extra_done;
	logic [ADDR_W-1:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rd;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, rs;
	acs_conv_s conv;
	int failures, num_checks;
	int res_t[4] = '{7, 9, 10, 12};
	logic [3:0] ends[8] = '{4'h3, 4'hA, 4'hE, 4'h7, 4'hB, 4'hC, 4'hD, 4'hF};

	acs_seq_ctrl acs_seq_ctrl_i (.aclk, .aresetn, .awvalid, .awready,
		.awaddr, .awprot(3'h0), .wvalid, .wready, .wdata, .wstrb, .bvalid,
		.bready, .bresp, .arvalid, .arready, .araddr, .arprot(3'h0), .rvalid,
		.rready, .rdata, .rresp, .conv, .sample_ready, .extra_done);
	acs_analog_model acs_analog_model_i (.aclk, .aresetn, .conv,
		.sample_ready, .extra_done);

	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end

	task automatic chk(input string nm, input logic [31:0] seen, exp);
		num_checks++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch %s exp %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d,
		input logic [1:0] er);
		bit ta;
		bit tw;
		ta = 0;
		tw = 0;
		@(posedge aclk);
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		awaddr <= a;
		wdata <= {24'h0, d};
		bready <= 1'b1;
		while (!(ta && tw)) begin
			@(posedge aclk);
			if (awready && !ta) begin
				ta = 1;
				awvalid <= 1'b0;
			end
			if (wready && !tw) begin
				tw = 1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (!bvalid);
		bready <= 1'b0;
		chk("bresp", bresp, er);
	endtask

	task automatic rdr(input logic [ADDR_W-1:0] a);
		@(posedge aclk);
		arvalid <= 1'b1;
		araddr <= a;
		rready <= 1'b1;
		do @(posedge aclk); while (!arready);
		arvalid <= 1'b0;
		do @(posedge aclk); while (!rvalid);
		rready <= 1'b0;
		rd = rdata;
		rs = rresp;
	endtask

	task automatic wait_n(input int n);
		int t;
		t = 0;
		while ((acs_analog_model_i.seen.size() < n || conv.busy) && t < 30000)
		begin
			@(posedge aclk);
			t++;
		end
		chk("count", acs_analog_model_i.seen.size(), n);
		chk("wait limit", 32'(t < 30000), 32'h1);
	endtask

	task automatic run_seq(input logic [3:0] e, input logic [1:0] rf, dv);
		int first;
		int n;
		first = e < 8 ? 0 : e < 12 ? 8 : e;
		n = e - first + 1;
		acs_analog_model_i.seen.delete();
		wr(ADDR_SEQ, {rf, dv, e}, RESP_OKAY);
		wr(ADDR_START, 8'h40, RESP_OKAY);
		rdr(ADDR_START);
		chk("seq busy", rd, 32'h40);
		wr(ADDR_SEQ, {~rf, ~dv, e}, RESP_OKAY);
		wait_n(n);
		for (int i = 0; i < n; i++) begin
			chk("conv", acs_analog_model_i.seen[i], {1'b1, 4'(first + i), rf,
				dv, 4'(res_t[dv])});
		end
		rdr(ADDR_SEQ);
		chk("readback", rd, {~rf, ~dv, e < 12 ? e + 4'h1 : e});
		rdr(ADDR_START);
		chk("seq done", rd, 32'h80);
		rdr(ADDR_START);
		chk("done clear", rd, 32'h0);
	endtask

	task automatic summarize;
		if (failures == 0 && num_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
		awaddr = '0;
		araddr = '0;
		wdata = '0;
		wstrb = 4'hF;
		failures = 0;
		num_checks = 0;
		void'($urandom(58222));
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		rdr(ADDR_SEQ);
		chk("seq reset", rd, 32'h10);
		wr(12'h004, 8'hFF, RESP_SLVERR);
		rdr(12'h004);
		chk("unmapped", {rs, rd[7:0]}, {RESP_SLVERR, 8'h00});
		wstrb <= 4'h0;
		wr(ADDR_SEQ, 8'hFF, RESP_OKAY);
		wstrb <= 4'hF;
		rdr(ADDR_SEQ);
		chk("masked write", rd, 32'h10);
		foreach (ends[i]) begin
			run_seq(ends[i], 2'($urandom), ends[i] < 12 ? 2'h0 : 2'($urandom));
		end
		acs_analog_model_i.seen.delete();
		wr(ADDR_EXTRA, 8'h02, RESP_OKAY);
		wait_n(1);
		chk("extra conv", acs_analog_model_i.seen[0], 13'h1207);
		rdr(ADDR_SEQ);
		chk("extra readback", rd[3:0], 4'h2);
		rdr(ADDR_EXTRA);
		chk("extra clear", rd, 32'h0);
		summarize;
	end

	initial begin
		repeat (80000) @(posedge aclk);
		failures++;
		summarize;
	end
endmodule
